// [logic/drive_control_status_words.sv]
// Command word decoder and state word assembler of the drive.
// Assumes the telegram layer strobes in one command word at a time and
// that the motor control supplies its status as plain synchronous levels.
`timescale 1ns/1ps
`default_nettype none

module drive_control_status_words #(
    parameter int WORD_W = drive_word_pkg::WORD_W
) (
    input  wire logic                      clock_i,
    input  wire logic                      rstn_i,
    // Telegram side
    input  wire logic                      cmd_strobe_i,
    input  wire logic [WORD_W-1:0]         command_word_i,
    input  wire logic signed [WORD_W-1:0]  bus_reference_i,
    input  wire logic                      link_ok_i,
    input  wire logic                      comm_fault_i,
    output logic      [WORD_W-1:0]         state_word_o,
    output logic signed [WORD_W-1:0]       actual_value_feedback_o,
    // Configuration
    input  wire logic                      profile_standard_i,
    input  wire logic [7:0]                relay1_function_i,
    input  wire logic [7:0]                relay4_function_i,
    input  wire logic [3:0]                active_setup_sel_i,
    input  wire logic [1:0]                reverse_source_i,
    input  wire logic                      reverse_input_i,
    input  wire logic signed [WORD_W-1:0]  max_frequency_i,
    input  wire logic signed [WORD_W-1:0]  low_limit_i,
    input  wire logic signed [WORD_W-1:0]  high_limit_i,
    // Drive status
    input  wire logic signed [WORD_W-1:0]  output_frequency_i,
    input  wire logic signed [WORD_W-1:0]  speed_reference_i,
    input  wire logic                      control_ready_i,
    input  wire logic                      power_ready_i,
    input  wire logic                      trip_i,
    input  wire logic                      error_i,
    input  wire logic                      trip_lock_i,
    input  wire logic                      warning_i,
    input  wire logic                      local_stop_i,
    input  wire logic                      local_reference_i,
    input  wire logic                      overtemp_restart_i,
    input  wire logic                      dc_voltage_fault_i,
    input  wire logic                      torque_limit_i,
    input  wire logic                      thermal_timer_over_i,
    // Decoded commands
    output logic [1:0]                     preset_select_o,
    output logic                           dc_brake_o,
    output logic                           coast_o,
    output logic                           hold_frequency_o,
    output logic                           ramp_stop_o,
    output logic                           start_enable_o,
    output logic                           trip_reset_o,
    output logic                           jog_o,
    output logic                           ramp_set2_o,
    output logic                           relay1_o,
    output logic                           relay4_o,
    output logic [1:0]                     parameter_set_o,
    output logic                           reverse_o,
    output logic signed [WORD_W-1:0]       frequency_target_o
);

    // ***********************************************
    // Command word capture
    // ***********************************************

    logic [WORD_W-1:0] cmd;
    logic              accept;
    logic              reset_pulse;

    assign accept = cmd_strobe_i & command_word_i[drive_word_pkg::CMD_VALID];

    // Whole word latched at once so every command changes together
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd <= drive_word_pkg::CMD_RESET_VAL;
        end else if (accept) begin
            cmd <= command_word_i;
        end
    end

    rising_edge_pulse u_reset_edge (
        .clock_i  (clock_i),
        .rstn_i   (rstn_i),
        .level_i  (command_word_i[drive_word_pkg::CMD_RESET]),
        .sample_i (accept),
        .pulse_o  (reset_pulse)
    );

    // ***********************************************
    // Reference scaling
    // ***********************************************

    // Percent word to frequency: value * max / 16384
    function automatic logic signed [WORD_W-1:0] scale_to_freq(
        input logic signed [WORD_W-1:0] pct,
        input logic signed [WORD_W-1:0] fmax
    );
        logic signed [2*WORD_W-1:0] prod;
        prod = pct * fmax;
        return WORD_W'(prod >>> 14);
    endfunction

    // Frequency to percent word: freq * 16384 / max
    function automatic logic signed [WORD_W-1:0] scale_to_pct(
        input logic signed [WORD_W-1:0] freq,
        input logic signed [WORD_W-1:0] fmax
    );
        logic signed [2*WORD_W-1:0] num;
        num = (2*WORD_W)'(freq) * (2*WORD_W)'(drive_word_pkg::FULL_SCALE);
        if (fmax == '0) begin
            return '0;
        end
        return WORD_W'(num / (2*WORD_W)'(fmax));
    endfunction

    // ***********************************************
    // Command decode
    // ***********************************************

    logic zero_hz;
    logic coast_cmd;
    logic stop_cmd;

    assign zero_hz   = (output_frequency_i == '0);
    assign coast_cmd = profile_standard_i ? ~cmd[1] : ~cmd[drive_word_pkg::CMD_COAST_N];
    assign stop_cmd  = profile_standard_i ? ~cmd[0] : ~cmd[drive_word_pkg::CMD_START];
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            preset_select_o  <= 2'h0;
            dc_brake_o       <= 1'b0;
            coast_o          <= 1'b1;
            hold_frequency_o <= 1'b0;
            ramp_stop_o      <= 1'b1;
            start_enable_o   <= 1'b0;
            jog_o            <= 1'b0;
            ramp_set2_o      <= 1'b0;
        end else begin
            preset_select_o  <= profile_standard_i ? 2'h0
                                : cmd[drive_word_pkg::CMD_PRESET_MSB:drive_word_pkg::CMD_PRESET_LSB];
            dc_brake_o       <= ~profile_standard_i & ~cmd[drive_word_pkg::CMD_DC_BRAKE_N];
            coast_o          <= coast_cmd;
            hold_frequency_o <= ~profile_standard_i & ~cmd[drive_word_pkg::CMD_HOLD_N];
            ramp_stop_o      <= stop_cmd;
            start_enable_o   <= ~coast_cmd & ~stop_cmd;
            jog_o            <= cmd[drive_word_pkg::CMD_JOG];
            ramp_set2_o      <= cmd[drive_word_pkg::CMD_RAMP2];
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trip_reset_o <= 1'b0;
        end else begin
            trip_reset_o <= reset_pulse;
        end
    end

    // Relays: bit commands, or on relay 1 in the standard profile a zero-hertz signal after a stop
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            relay1_o <= 1'b0;
            relay4_o <= 1'b0;
        end else begin
            relay1_o <= ((relay1_function_i == drive_word_pkg::RELAY_FN_BIT11) & cmd[drive_word_pkg::CMD_RELAY1])
                      | ((relay1_function_i == drive_word_pkg::RELAY_FN_ZERO_HZ) & profile_standard_i
                         & (~cmd[0] | ~cmd[1]) & zero_hz);
            relay4_o <= (relay4_function_i == drive_word_pkg::RELAY_FN_BIT12) & cmd[drive_word_pkg::CMD_RELAY4];
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            parameter_set_o <= 2'h0;
        end else if (active_setup_sel_i == drive_word_pkg::SETUP_MULTI) begin
            parameter_set_o <= cmd[drive_word_pkg::CMD_SETUP_MSB:drive_word_pkg::CMD_SETUP_LSB];
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reverse_o <= 1'b0;
        end else begin
            unique case (reverse_source_i)
                drive_word_pkg::REV_SERIAL:    reverse_o <= cmd[drive_word_pkg::CMD_REVERSE];
                drive_word_pkg::REV_LOGIC_OR:  reverse_o <= cmd[drive_word_pkg::CMD_REVERSE] | reverse_input_i;
                drive_word_pkg::REV_LOGIC_AND: reverse_o <= cmd[drive_word_pkg::CMD_REVERSE] & reverse_input_i;
                default:                       reverse_o <= reverse_input_i;
            endcase
        end
    end

    // Target frequency: scaled bus reference; in the native profile also held output frequency, or kept unchanged on jog
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frequency_target_o <= '0;
        end else if (profile_standard_i) begin
            frequency_target_o <= scale_to_freq(bus_reference_i, max_frequency_i);
        end else if (!cmd[drive_word_pkg::CMD_HOLD_N]) begin
            frequency_target_o <= output_frequency_i;
        end else if (!cmd[drive_word_pkg::CMD_JOG]) begin
            frequency_target_o <= scale_to_freq(bus_reference_i, max_frequency_i);
        end
    end

    // ***********************************************
    // State word
    // ***********************************************

    logic [WORD_W-1:0] next_state_word;

    always_comb begin
        next_state_word = '0;
        next_state_word[drive_word_pkg::ST_CTRL_READY]  = control_ready_i & ~trip_i;
        next_state_word[drive_word_pkg::ST_DRIVE_READY] = control_ready_i & power_ready_i & ~trip_i;
        next_state_word[drive_word_pkg::ST_ENABLE]      = ~coast_cmd & ~trip_i;
        next_state_word[drive_word_pkg::ST_TRIP]        = trip_i;
        next_state_word[drive_word_pkg::ST_ERROR]       = error_i;
        next_state_word[drive_word_pkg::ST_TRIPLOCK]    = trip_lock_i;
        next_state_word[drive_word_pkg::ST_WARNING]     = warning_i;
        next_state_word[drive_word_pkg::ST_AT_REF]      = (output_frequency_i == speed_reference_i);
        next_state_word[drive_word_pkg::ST_BUS_CTRL]    = ~local_stop_i & ~local_reference_i;
        next_state_word[drive_word_pkg::ST_FREQ_OK]     = (output_frequency_i > low_limit_i)
                                                         & (output_frequency_i < high_limit_i);
        next_state_word[drive_word_pkg::ST_RUNNING]     = ~stop_cmd | ~zero_hz;
        next_state_word[drive_word_pkg::ST_OVERTEMP]    = overtemp_restart_i;
        next_state_word[drive_word_pkg::ST_VOLTAGE]     = dc_voltage_fault_i;
        next_state_word[drive_word_pkg::ST_TORQUE]      = torque_limit_i;
        next_state_word[drive_word_pkg::ST_TIMER]       = thermal_timer_over_i;
        if (!link_ok_i || comm_fault_i) begin
            next_state_word = '0;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_word_o <= drive_word_pkg::STATE_RESET_VAL;
        end else begin
            state_word_o <= next_state_word;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            actual_value_feedback_o <= '0;
        end else begin
            actual_value_feedback_o <= scale_to_pct(output_frequency_i, max_frequency_i);
        end
    end

endmodule

`default_nettype wire

// [logic/drive_word_pkg.sv]
// Constants for the drive command word decoder and state word assembler.
// Assumes one device clock; all words are 16 bits wide.

package drive_word_pkg;

    localparam int WORD_W = 16;

    // Command word bit positions
    localparam int CMD_PRESET_LSB = 0;
    localparam int CMD_PRESET_MSB = 1;
    localparam int CMD_DC_BRAKE_N = 2;
    localparam int CMD_COAST_N    = 3;
    localparam int CMD_HOLD_N     = 5;
    localparam int CMD_START      = 6;
    localparam int CMD_RESET      = 7;
    localparam int CMD_JOG        = 8;
    localparam int CMD_RAMP2      = 9;
    localparam int CMD_VALID      = 10;
    localparam int CMD_RELAY1     = 11;
    localparam int CMD_RELAY4     = 12;
    localparam int CMD_SETUP_LSB  = 13;
    localparam int CMD_SETUP_MSB  = 14;
    localparam int CMD_REVERSE    = 15;

    // State word bit positions
    localparam int ST_CTRL_READY  = 0;
    localparam int ST_DRIVE_READY = 1;
    localparam int ST_ENABLE      = 2;
    localparam int ST_TRIP        = 3;
    localparam int ST_ERROR       = 4;
    localparam int ST_TRIPLOCK    = 6;
    localparam int ST_WARNING     = 7;
    localparam int ST_AT_REF      = 8;
    localparam int ST_BUS_CTRL    = 9;
    localparam int ST_FREQ_OK     = 10;
    localparam int ST_RUNNING     = 11;
    localparam int ST_OVERTEMP    = 12;
    localparam int ST_VOLTAGE     = 13;
    localparam int ST_TORQUE      = 14;
    localparam int ST_TIMER       = 15;

    // Configuration option codes
    localparam logic [7:0] RELAY_FN_ZERO_HZ = 8'h1f;  // option 31
    localparam logic [7:0] RELAY_FN_BIT11   = 8'h24;  // option 36
    localparam logic [7:0] RELAY_FN_BIT12   = 8'h25;  // option 37
    localparam logic [3:0] SETUP_MULTI      = 4'h9;   // option 9

    typedef enum logic [1:0] {
        REV_DIGITAL,
        REV_SERIAL,
        REV_LOGIC_AND,
        REV_LOGIC_OR
    } rev_src_e;

    // Speed scaling
    localparam logic signed [15:0] FULL_SCALE = 16'sh4000;

    // Values after reset
    localparam logic [15:0] CMD_RESET_VAL   = 16'h0000;
    localparam logic [15:0] STATE_RESET_VAL = 16'h0000;

endpackage

// [logic/rising_edge_pulse.sv]
// Rising edge detector giving a one-cycle pulse.
// Assumes the input is synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none

module rising_edge_pulse (
    input  wire logic clock_i,
    input  wire logic rstn_i,
    input  wire logic level_i,
    input  wire logic sample_i,
    output logic      pulse_o
);

    logic last;

    // Level is only looked at when sample_i is high
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last <= 1'b0;
        end else if (sample_i) begin
            last <= level_i;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= sample_i & level_i & ~last;
        end
    end

endmodule

`default_nettype wire

// [sim/status_checker_sva.sv]
// Checker for the command decoder and state word assembler.
// Sees only the top module's ports; bound in below.
`timescale 1ns/1ps
`default_nettype none

module status_checker #(
    parameter int WORD_W = 16
) (
    input wire logic              clock_i,
    input wire logic              rstn_i,
    input wire logic              cmd_strobe_i,
    input wire logic [WORD_W-1:0] command_word_i,
    input wire logic              link_ok_i,
    input wire logic              comm_fault_i,
    input wire logic              profile_standard_i,
    input wire logic [7:0]        relay4_function_i,
    input wire logic              trip_i,
    input wire logic [WORD_W-1:0] state_word_o,
    input wire logic [1:0]        preset_select_o,
    input wire logic              coast_o,
    input wire logic              jog_o,
    input wire logic              relay4_o,
    input wire logic              trip_reset_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // ********************************
    // Command decode
    // ********************************
    sequence taken_s;
        cmd_strobe_i && command_word_i[10];
    endsequence
    sequence native_s;
        taken_s ##0 !profile_standard_i;
    endsequence

    a_preset_pick: assert property (native_s |-> ##2 preset_select_o == $past(command_word_i[1:0], 2))
        else $error("preset select wrong");
    a_coast_cmd: assert property (native_s |-> ##2 coast_o == !$past(command_word_i[3], 2))
        else $error("coast wrong");
    a_jog_select: assert property (native_s |-> ##2 jog_o == $past(command_word_i[8], 2))
        else $error("jog wrong");
    a_relay4_gate: assert property (native_s |-> ##2 relay4_o ==
        ($past(command_word_i[12], 2) && relay4_function_i == drive_word_pkg::RELAY_FN_BIT12))
        else $error("relay four wrong");
    a_invalid_ignored: assert property (!(cmd_strobe_i && command_word_i[10]) ##1 $stable(profile_standard_i) |->
        ##1 ($stable(coast_o) && $stable(jog_o) && $stable(preset_select_o)))
        else $error("output moved without accepted word");
    a_reset_pulse_cause: assert property (trip_reset_o |->
        ($past(command_word_i[7], 2) && $past(cmd_strobe_i, 2)) ##1 !trip_reset_o)
        else $error("trip reset pulse wrong");

    // ********************************
    // State word
    // ********************************
    a_link_loss_zero: assert property ((!link_ok_i || comm_fault_i) |=> state_word_o == '0)
        else $error("state word not cleared");
    a_trip_flag_bits: assert property ((link_ok_i && !comm_fault_i) |=>
        (state_word_o[3] == $past(trip_i) && !state_word_o[5]))
        else $error("trip flag wrong");
endmodule

bind drive_control_status_words status_checker #(.WORD_W(WORD_W)) chk_u (
    .clock_i, .rstn_i, .cmd_strobe_i, .command_word_i, .link_ok_i, .comm_fault_i,
    .profile_standard_i, .relay4_function_i, .trip_i, .state_word_o, .preset_select_o,
    .coast_o, .jog_o, .relay4_o, .trip_reset_o);

`default_nettype wire

// [sim/bus_master_model.sv]
// Fieldbus master model: sends command words and a speed reference.
// Its tasks are called from the testbench just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
    input  wire logic         clock_i,
    output var  logic         cmd_strobe_o,
    output var  logic [15:0]  command_word_o,
    output var  logic [15:0]  bus_reference_o
);
    // ********************************
    // Telegram driving
    // ********************************
    initial begin
        cmd_strobe_o = 1'b0;
        command_word_o = 16'h0000;
        bus_reference_o = 16'h0000;
    end

    // Word stands only with the strobe; afterwards the line shows junk
    task automatic send(input logic [15:0] w, input bit more);
        cmd_strobe_o <= 1'b1;
        command_word_o <= w;
        @(posedge clock_i);
        if (!more) begin
            cmd_strobe_o <= 1'b0;
            command_word_o <= ~w;
        end
    endtask

    // Signed percentage, 16'h4000 being full scale
    task automatic set_reference(input logic [15:0] r);
        bus_reference_o <= r;
    endtask
endmodule

`default_nettype wire

// [sim/tb_drive_control_status_words.sv]
// Testbench for the command decoder and state word assembler.
// Command words come from the master model; status inputs are driven here.
`timescale 1ns/1ps
`default_nettype none

module tb_drive_control_status_words;
    logic        clock_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        stb, link_ok, fault, prof, rev_in, dcb, coast, hold, rstop, start, trst, jog, rmp2, rl1, rl4, rev;
    logic [15:0] word, bref, sw, fb, tgt, fmax, lo, hi, ofr, sref;
    logic [7:0]  r1fn, r4fn;
    logic [3:0]  ssel;
    logic [1:0]  rsrc, pre, pset;
    logic [11:0] fl;
    int          fails = 0;
    int          tests_run = 0;
    int          cycles = 0;

    initial forever #5 clock_i = ~clock_i;

    bus_master_model master_u (.clock_i, .cmd_strobe_o(stb), .command_word_o(word), .bus_reference_o(bref));
    drive_control_status_words dut_u (.clock_i, .rstn_i, .cmd_strobe_i(stb), .command_word_i(word),
        .bus_reference_i(bref), .link_ok_i(link_ok), .comm_fault_i(fault), .state_word_o(sw),
        .actual_value_feedback_o(fb), .profile_standard_i(prof), .relay1_function_i(r1fn),
        .relay4_function_i(r4fn), .active_setup_sel_i(ssel), .reverse_source_i(rsrc),
        .reverse_input_i(rev_in), .max_frequency_i(fmax), .low_limit_i(lo), .high_limit_i(hi),
        .output_frequency_i(ofr), .speed_reference_i(sref), .control_ready_i(fl[11]),
        .power_ready_i(fl[10]), .trip_i(fl[9]), .error_i(fl[8]), .trip_lock_i(fl[7]),
        .warning_i(fl[6]), .local_stop_i(fl[5]), .local_reference_i(fl[4]),
        .overtemp_restart_i(fl[3]), .dc_voltage_fault_i(fl[2]), .torque_limit_i(fl[1]),
        .thermal_timer_over_i(fl[0]), .preset_select_o(pre), .dc_brake_o(dcb), .coast_o(coast),
        .hold_frequency_o(hold), .ramp_stop_o(rstop), .start_enable_o(start), .trip_reset_o(trst),
        .jog_o(jog), .ramp_set2_o(rmp2), .relay1_o(rl1), .relay4_o(rl4), .parameter_set_o(pset),
        .reverse_o(rev), .frequency_target_o(tgt));

    // ********************************
    // Shared tasks
    // ********************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic settle();
        repeat (2) @(posedge clock_i);
        #1;
    endtask

    task automatic cmd(input logic [15:0] w);
        @(posedge clock_i);
        master_u.send(w, 1'b0);
        settle();
    endtask

    function automatic logic [15:0] dec();
        return 16'({pre, dcb, coast, hold, start, rstop, jog, rmp2});
    endfunction

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_decode();
        logic [15:0] e;
        for (int i = 0; i < 4; i++) begin
            e = 16'({i[1:0], !i[0], !i[0], !i[0], i[0], !i[0], i[0], i[0]});
            cmd(16'h0400 | 16'(i) | (i[0] ? 16'h036c : 16'h0000));
            check("decode", dec(), e);
        end
        cmd(16'hfbff);
        check("ignored", dec(), e);
    endtask

    task automatic t_trip();
        int n;
        n = 0;
        @(posedge clock_i);
        master_u.send(16'h0400, 1'b1);
        master_u.send(16'h0480, 1'b1);
        master_u.send(16'h0480, 1'b0);
        repeat (6) begin
            #1;
            n += (trst === 1'b1);
            @(posedge clock_i);
        end
        check("trip pulses", 16'(n), 16'h0001);
    endtask

    task automatic t_relay_setup();
        for (int j = 0; j < 2; j++) begin
            @(posedge clock_i);
            r1fn <= j ? drive_word_pkg::RELAY_FN_BIT11 : 8'h00;
            r4fn <= j ? drive_word_pkg::RELAY_FN_BIT12 : drive_word_pkg::RELAY_FN_BIT11;
            cmd(16'h1c00);
            check("relays", 16'({rl1, rl4}), j ? 16'h0003 : 16'h0000);
        end
        @(posedge clock_i);
        ssel <= drive_word_pkg::SETUP_MULTI;
        cmd(16'h4400);
        check("set", 16'(pset), 16'h0002);
        @(posedge clock_i);
        ssel <= 4'h0;
        cmd(16'h2400);
        check("set kept", 16'(pset), 16'h0002);
        for (int s = 0; s < 4; s++) begin
            @(posedge clock_i);
            rsrc <= 2'(s);
            rev_in <= (s == 2);
            cmd(16'h8400);
            check("reverse", 16'(rev), 16'(s != 0));
        end
    endtask

    task automatic t_speed();
        @(posedge clock_i);
        master_u.set_reference(16'h2000);
        cmd(16'h0460);
        check("target", tgt, 16'h01f4);
        check("feedback", fb, 16'h2000);
        @(posedge clock_i);
        master_u.set_reference(16'hc000);
        cmd(16'h0460);
        check("target neg", tgt, 16'hfc18);
        cmd(16'h0440);
        check("frozen", tgt, 16'h01f4);
        cmd(16'h0560);
        check("jog kept", tgt, 16'h01f4);
    endtask

    task automatic t_state();
        @(posedge clock_i);
        fl <= 12'hfff;
        settle();
        check("flags", sw & 16'hf2fb, 16'hf0d8);
        check("speed", sw & 16'h0d00, 16'h0d00);
        @(posedge clock_i);
        fl <= 12'hc00;
        ofr <= 16'h0384;
        settle();
        check("ready", sw & 16'hf2fb, 16'h0203);
        check("limit", sw & 16'h0d00, 16'h0800);
        @(posedge clock_i);
        link_ok <= 1'b0;
        settle();
        check("link lost", sw, 16'h0000);
        @(posedge clock_i);
        link_ok <= 1'b1;
        fault <= 1'b1;
        settle();
        check("fault", sw, 16'h0000);
    endtask

    task automatic t_standard();
        @(posedge clock_i);
        fault <= 1'b0;
        prof <= 1'b1;
        r1fn <= drive_word_pkg::RELAY_FN_ZERO_HZ;
        ofr <= 16'h0000;
        cmd(16'h0400);
        check("std stop", 16'({coast, rstop, rl1}), 16'h0007);
        check("enable off", 16'(sw[2]), 16'h0000);
        cmd(16'h0403);
        check("std run", 16'({coast, rstop, rl1}), 16'h0000);
        check("enable on", 16'(sw[2]), 16'h0001);
    endtask

    initial begin
        {link_ok, fault, prof, rev_in} <= 4'b1000;
        {fmax, lo, hi, ofr, sref} <= {16'h03e8, 16'h0064, 16'h0384, 16'h01f4, 16'h01f4};
        {r1fn, r4fn, ssel, rsrc, fl} <= {8'h00, 8'h00, 4'h0, 2'h0, 12'hc00};
        repeat (8) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_decode();
        t_trip();
        t_relay_setup();
        t_speed();
        t_state();
        t_standard();
        tally_and_finish();
    end

    // Cuts a hang short
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            tally_and_finish();
        end
    end
endmodule

`default_nettype wire
